// ### ffwave_defs.svh
// constants for the fast-feed drive pulse waveform generator
// Operation
// - reverse drive: three shaped pulses, then 4 or 8 chopped pulses; third 4.88/6.84 ms
// - each reverse chopped pulse period is 0.976 ms
// - chop duty 1/2 is 0.488 high and low; 1/4 is 0.732 high, 0.244 low
// - one drive pulse starts at each selected motor clock rising edge
// - three-bit motor clock code selects 128 Hz down to 16 Hz
// - motor clock select resets to 128 Hz
// - eight hertz select overrides the three-bit motor clock code
// - clock selection changes only at the end of the running motor clock cycle
// - normal lead width is 2.93 ms plus 0.244 ms per code step
// - normal lead width code resets to zero, 2.93 ms
// - normal chop count code gives 4, 6, 8 or 10 pulses
// - normal chop count code resets to four pulses
// - suppress bit removes all normal chopped pulses
// - with chops suppressed the output interval still spans the programmed chop time
// - normal chop duty bit: one is 1/2, zero is 1/4, reset zero
// - a chop train still running is cut off when the next motor clock pulse starts
// - direction bit: one reverse, zero normal, normal after reset
// - drive pulses alternate between the two coil outputs, one per step
`ifndef FFWAVE_DEFS_SVH
`define FFWAVE_DEFS_SVH

`define CLK_PERIOD_NS    40
`define TICK_PERIOD_NS   244141

`define OFS_CTRL         12'h000
`define OFS_NORMAL       12'h004
`define OFS_REVERSE      12'h008
`define OFS_STATUS       12'h00c

`define CTRL_ENABLE      0
`define CTRL_DIR         1
`define CTRL_EIGHT       2
`define CTRL_SEL_LSB     3
`define NORM_WIDTH_LSB   0
`define NORM_COUNT_LSB   4
`define NORM_SUPPRESS    6
`define NORM_DUTY        7
`define REV_G1_LSB       0
`define REV_G2_LSB       3
`define REV_G3           6
`define REV_GRNUM        7
`define REV_DUTY         8
`define STAT_BUSY        0
`define STAT_SIDE        1
`define STAT_EIGHT       2
`define STAT_SEL_LSB     3

`define RST_CLK_SEL      3'h7
`define RST_LEAD         4'h0
`define RST_CHOP_COUNT   2'h0
`define RST_DUTY         1'b0
`define RST_DIR          1'b0

`define LEAD_BASE_TICKS  5'h0c
`define G1_BASE_TICKS    5'h03
`define G2_BASE_TICKS    5'h07
`define G3_SHORT_TICKS   5'h14
`define G3_LONG_TICKS    5'h1c
`define CHOP_BASE_PULSES 4'h4
`define GR_SHORT_PULSES  4'h4
`define GR_LONG_PULSES   4'h8
`define HIGH_HALF_TICKS  2'h2
`define HIGH_QUART_TICKS 2'h3

`define PER_128HZ        10'h020
`define PER_85HZ         10'h030
`define PER_64HZ         10'h040
`define PER_51HZ         10'h050
`define PER_42HZ         10'h060
`define PER_32HZ         10'h080
`define PER_25HZ         10'h0a0
`define PER_16HZ         10'h100
`define PER_8HZ          10'h200

`endif

// ### wave_pkg.sv
// types shared by the waveform generator modules
package wave_pkg;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'b00001,
    ST_G1   = 5'b00010,
    ST_G2   = 5'b00100,
    ST_G3   = 5'b01000,
    ST_CHOP = 5'b10000
  } wave_state_type;

endpackage

// ### shape_if.sv
// carrier between the register side and the pulse shaper
`timescale 1ns/1ps
interface shape_if;
  logic       tick;
  logic       start;
  logic       reverse;
  logic [4:0] g1_ticks;
  logic [4:0] g2_ticks;
  logic [4:0] third_ticks;
  logic [3:0] chop_pulses;
  logic [1:0] chop_high;
  logic       chop_mute;
  logic       level;
  logic       busy;

  modport ctrl
  (
    output tick, start, reverse, g1_ticks, g2_ticks, third_ticks,
    output chop_pulses, chop_high, chop_mute,
    input  level, busy
  );
  modport shaper
  (
    input  tick, start, reverse, g1_ticks, g2_ticks, third_ticks,
    input  chop_pulses, chop_high, chop_mute,
    output level, busy
  );
endinterface

// ### wave_shaper.sv
// pulse shaper: shaped pulses then chopped train, timed in 1/4096 s ticks
`timescale 1ns/1ps
`include "ffwave_defs.svh"
module wave_shaper
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // link to register side
  shape_if.shaper  sh
);
  import wave_pkg::*;

  wave_state_type state;
  wave_state_type next_state;
  logic [4:0]     ph_cnt;
  logic [1:0]     sub_cnt;
  logic [3:0]     pulse_cnt;

  wire [4:0] phase_len  = (state == ST_G1) ? sh.g1_ticks :
                          (state == ST_G2) ? sh.g2_ticks : sh.third_ticks;
  wire       phase_done = sh.tick && (ph_cnt == phase_len - 5'h01);
  wire       in_chop    = (state == ST_CHOP);
  wire       period_end = in_chop && sh.tick && (sub_cnt == 2'h3);
  wire       chop_last  = period_end && (pulse_cnt == sh.chop_pulses - 4'h1);

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = ST_IDLE;
      ST_G1:   next_state = phase_done ? ST_G2 : ST_G1;
      ST_G2:   next_state = phase_done ? ST_G3 : ST_G2;
      ST_G3:   next_state = phase_done ? ST_CHOP : ST_G3;
      ST_CHOP: next_state = chop_last ? ST_IDLE : ST_CHOP;
      default: next_state = ST_IDLE;
    endcase
    // a new step always restarts, cutting any train still running
    if (sh.start)
      next_state = sh.reverse ? ST_G1 : ST_G3;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state     <= ST_IDLE;
      ph_cnt    <= 5'h00;
      sub_cnt   <= 2'h0;
      pulse_cnt <= 4'h0;
    end
    else
    begin
      state     <= next_state;
      ph_cnt    <= (sh.start || phase_done) ? 5'h00 : (sh.tick ? ph_cnt + 5'h01 : ph_cnt);
      sub_cnt   <= sh.start ? 2'h0 : ((in_chop && sh.tick) ? sub_cnt + 2'h1 : sub_cnt);
      pulse_cnt <= sh.start ? 4'h0 : (period_end ? pulse_cnt + 4'h1 : pulse_cnt);
    end
  end

  // muted chops still run their periods, only the level is held low
  assign sh.level = (state == ST_G1) || (state == ST_G3) ||
                    (in_chop && !sh.chop_mute && (sub_cnt < sh.chop_high));
  assign sh.busy  = (state != ST_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence lead_done_s;
    (state == ST_G3) && phase_done && !sh.start;
  endsequence
  sequence chop_running_s;
    (state == ST_CHOP) && !sh.chop_mute;
  endsequence

  a_normal_order_chop: assert property (lead_done_s |=> (state == ST_CHOP) && (sub_cnt == 2'h0))
    else $error("chop train did not follow the lead pulse");
  a_chop_period_wrap: assert property (period_end && !chop_last && !sh.start |=> in_chop && sub_cnt == 2'h0)
    else $error("chop period is not four ticks");
  a_chop_high_first: assert property (chop_running_s and (sub_cnt == 2'h0) |-> sh.level)
    else $error("chop period does not open high");
  a_chop_low_last: assert property (chop_running_s and (sub_cnt == 2'h3) |-> !sh.level)
    else $error("chop period does not close low");
  a_mute_keeps_low: assert property ((state == ST_CHOP) && sh.chop_mute |-> !sh.level ##0 sh.busy)
    else $error("suppressed chop drove the coil");
  a_restart_cuts_train: assert property (sh.start |=> (state == ST_G1 || state == ST_G3) && ph_cnt == 5'h00)
    else $error("new step did not restart the waveform");
  a_reverse_starts_g1: assert property (sh.start && sh.reverse |=> state == ST_G1)
    else $error("reverse step did not start with the first shaped pulse");
endmodule

// ### fast_feed_pulse_waveform_gen.sv
// fast-feed drive pulse generator for one motor channel with apb registers
`timescale 1ns/1ps
`include "ffwave_defs.svh"
module fast_feed_pulse_waveform_gen
#(
  parameter int unsigned TICK_CYCLES = (`TICK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // motor coil drive
  output logic             drive_out_a,
  output logic             drive_out_b
);
  import wave_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // helper functions

  function automatic logic [9:0] motor_period(input logic [2:0] sel, input logic eight);
    logic [9:0] per;
    per = `PER_128HZ;
    case (sel)
      3'h7:    per = `PER_128HZ;
      3'h6:    per = `PER_85HZ;
      3'h5:    per = `PER_64HZ;
      3'h4:    per = `PER_51HZ;
      3'h3:    per = `PER_42HZ;
      3'h2:    per = `PER_32HZ;
      3'h1:    per = `PER_25HZ;
      3'h0:    per = `PER_16HZ;
      default: per = `PER_128HZ;
    endcase
    if (eight)
      per = `PER_8HZ;
    return per;
  endfunction

  function automatic logic [1:0] high_ticks(input logic half);
    return half ? `HIGH_HALF_TICKS : `HIGH_QUART_TICKS;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic       drive_enable;
  logic       direction_select;
  logic       eight_hz_clock_select;
  logic [2:0] motor_clock_select;
  logic [3:0] normal_first_pulse_width;
  logic [1:0] normal_chop_count;
  logic       normal_chop_suppress;
  logic       normal_chop_duty;
  logic [2:0] reverse_first_width;
  logic [2:0] reverse_second_width;
  logic       reverse_third_long;
  logic       reverse_chop_long;
  logic       reverse_chop_duty;

  // motor clock and step state
  logic [15:0] tick_cnt;
  logic        tick;
  logic [9:0]  phase_cnt;
  logic [2:0]  active_sel;
  logic        active_eight;
  logic        next_side;
  logic        cur_side;

  shape_if sh();

  //////////////////////////////////////////////////////////////////////////////
  // apb decode: one wait state, answer from flops

  wire        access    = psel && penable && pready;
  wire        wr_commit = access && pwrite;
  wire        answering = psel && penable && !pready;
  wire        hit_ctrl  = (paddr == `OFS_CTRL);
  wire        hit_norm  = (paddr == `OFS_NORMAL);
  wire        hit_rev   = (paddr == `OFS_REVERSE);
  wire        hit_stat  = (paddr == `OFS_STATUS);
  wire        mapped    = hit_ctrl || hit_norm || hit_rev || hit_stat;

  wire [31:0] ctrl_word = {26'h0, motor_clock_select, eight_hz_clock_select, direction_select, drive_enable};
  wire [31:0] norm_word = {24'h0, normal_chop_duty, normal_chop_suppress, normal_chop_count,
                           normal_first_pulse_width};
  wire [31:0] rev_word  = {23'h0, reverse_chop_duty, reverse_chop_long, reverse_third_long,
                           reverse_second_width, reverse_first_width};
  wire [31:0] stat_word = {26'h0, active_sel, active_eight, next_side, sh.busy};
  wire [31:0] rd_word   = hit_ctrl ? ctrl_word :
                          hit_norm ? norm_word :
                          hit_rev  ? rev_word  :
                          hit_stat ? stat_word : 32'h0;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= answering;
      prdata  <= (answering && !pwrite) ? rd_word : 32'h0;
      pslverr <= answering && !mapped;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      drive_enable          <= 1'b0;
      direction_select      <= `RST_DIR;
      eight_hz_clock_select <= 1'b0;
      motor_clock_select    <= `RST_CLK_SEL;
    end
    else if (wr_commit && hit_ctrl)
    begin
      drive_enable          <= pwdata[`CTRL_ENABLE];
      direction_select      <= pwdata[`CTRL_DIR];
      eight_hz_clock_select <= pwdata[`CTRL_EIGHT];
      motor_clock_select    <= pwdata[`CTRL_SEL_LSB +: 3];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      normal_first_pulse_width <= `RST_LEAD;
      normal_chop_count        <= `RST_CHOP_COUNT;
      normal_chop_suppress     <= 1'b0;
      normal_chop_duty         <= `RST_DUTY;
    end
    else if (wr_commit && hit_norm)
    begin
      normal_first_pulse_width <= pwdata[`NORM_WIDTH_LSB +: 4];
      normal_chop_count        <= pwdata[`NORM_COUNT_LSB +: 2];
      normal_chop_suppress     <= pwdata[`NORM_SUPPRESS];
      normal_chop_duty         <= pwdata[`NORM_DUTY];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      reverse_first_width  <= 3'h0;
      reverse_second_width <= 3'h0;
      reverse_third_long   <= 1'b0;
      reverse_chop_long    <= 1'b0;
      reverse_chop_duty    <= `RST_DUTY;
    end
    else if (wr_commit && hit_rev)
    begin
      reverse_first_width  <= pwdata[`REV_G1_LSB +: 3];
      reverse_second_width <= pwdata[`REV_G2_LSB +: 3];
      reverse_third_long   <= pwdata[`REV_G3];
      reverse_chop_long    <= pwdata[`REV_GRNUM];
      reverse_chop_duty    <= pwdata[`REV_DUTY];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // 1/4096 s timebase and motor clock

  wire [9:0] period     = motor_period(active_sel, active_eight);
  wire       tick_wrap  = (tick_cnt == 16'(TICK_CYCLES - 1));
  wire       period_end = tick && (phase_cnt == period - 10'h001);
  wire       step_start = period_end && drive_enable;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tick_cnt <= 16'h0;
      tick     <= 1'b0;
    end
    else
    begin
      tick_cnt <= tick_wrap ? 16'h0 : tick_cnt + 16'h1;
      tick     <= tick_wrap;
    end
  end

  // a new selection is adopted only when the running cycle completes
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      phase_cnt    <= 10'h000;
      active_sel   <= `RST_CLK_SEL;
      active_eight <= 1'b0;
    end
    else if (period_end)
    begin
      phase_cnt    <= 10'h000;
      active_sel   <= motor_clock_select;
      active_eight <= eight_hz_clock_select;
    end
    else if (tick)
      phase_cnt <= phase_cnt + 10'h001;
  end

  //////////////////////////////////////////////////////////////////////////////
  // shaper setup

  assign sh.tick        = tick;
  assign sh.start       = step_start;
  assign sh.reverse     = direction_select;
  assign sh.g1_ticks    = `G1_BASE_TICKS + {2'h0, reverse_first_width};
  assign sh.g2_ticks    = `G2_BASE_TICKS + {2'h0, reverse_second_width};
  assign sh.third_ticks = direction_select ?
                          (reverse_third_long ? `G3_LONG_TICKS : `G3_SHORT_TICKS) :
                          (`LEAD_BASE_TICKS + {1'b0, normal_first_pulse_width});
  assign sh.chop_pulses = direction_select ?
                          (reverse_chop_long ? `GR_LONG_PULSES : `GR_SHORT_PULSES) :
                          (`CHOP_BASE_PULSES + {1'b0, normal_chop_count, 1'b0});
  assign sh.chop_high   = high_ticks(direction_select ? reverse_chop_duty : normal_chop_duty);
  assign sh.chop_mute   = !direction_select && normal_chop_suppress;

  wave_shaper u_shaper
  (
    .core_clk (core_clk),
    .rst      (rst),
    .sh       (sh.shaper)
  );

  //////////////////////////////////////////////////////////////////////////////
  // coil outputs alternate per step

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      next_side   <= 1'b0;
      cur_side    <= 1'b0;
      drive_out_a <= 1'b0;
      drive_out_b <= 1'b0;
    end
    else
    begin
      if (step_start)
      begin
        cur_side  <= next_side;
        next_side <= !next_side;
      end
      drive_out_a <= sh.level && !cur_side;
      drive_out_b <= sh.level && cur_side;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence reset_release_s;
    $past(rst) && !rst;
  endsequence

  a_clock_sel_reset: assert property (reset_release_s |-> motor_clock_select == 3'h7 && period == `PER_128HZ)
    else $error("motor clock does not reset to 128 Hz");
  a_lead_width_reset: assert property (reset_release_s |-> sh.third_ticks == 5'h0c || direction_select)
    else $error("lead width does not reset to 2.93 ms");
  a_chop_count_reset: assert property (reset_release_s |-> normal_chop_count == 2'h0 && sh.chop_pulses == 4'h4)
    else $error("normal chop count does not reset to four");
  a_duty_dir_reset: assert property (reset_release_s |-> !normal_chop_duty && !direction_select)
    else $error("duty or direction reset wrong");
  a_start_on_edge: assert property (step_start |-> tick && phase_cnt == period - 10'h001 ##1 phase_cnt == 10'h000)
    else $error("step started away from the motor clock edge");
  a_sel_at_boundary: assert property (!$stable(active_sel) |-> $past(period_end))
    else $error("motor clock changed mid cycle");
  a_eight_hz_period: assert property (active_eight |-> period == `PER_8HZ)
    else $error("eight hertz select not honoured");
  a_outputs_exclusive: assert property (!(drive_out_a && drive_out_b))
    else $error("both coil outputs driven together");
  a_side_alternates: assert property (step_start |=> cur_side == $past(next_side) && next_side != cur_side)
    else $error("step did not alternate coil side");
  a_step_drives_coil: assert property (step_start |-> ##2 (drive_out_a || drive_out_b))
    else $error("coil not driven two clocks after the step");
  a_low_level_quiet: assert property (!sh.level |=> !drive_out_a && !drive_out_b)
    else $error("coil driven while the waveform is low");
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing broken");
  a_unmapped_error: assert property (psel && penable && !pready && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not flagged");
  a_read_idle_zero: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error shown outside the answer cycle");
endmodule

// ### coil_model.sv
// coil pair model: measures each burst of drive on either coil
`timescale 1ns/1ps
module coil_model
#(
  parameter int QUIET = 80
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // coil terminals
  input  wire logic        coil_a,
  input  wire logic        coil_b,
  // burst report
  output logic             rep_valid,
  output logic             rep_side,
  output logic      [15:0] rep_len,
  output logic      [15:0] rep_gap
);
  logic [15:0] now;
  logic [15:0] last_start;
  logic [15:0] hi [2];
  logic [15:0] lo [2];
  logic [15:0] gap [2];
  wire  [1:0]  coil = {coil_b, coil_a};
  // a burst ends once its coil has rested longer than any gap inside one step
  always_ff @(posedge core_clk)
  begin
    rep_valid <= 1'b0;
    now <= rst ? 16'h0 : now + 16'h1;
    if (rst)
      last_start <= 16'h0;
    for (int k = 0; k < 2; k++)
    begin
      if (rst)
      begin
        hi[k] <= 16'h0;
        lo[k] <= 16'h0;
        gap[k] <= 16'h0;
      end
      else if (coil[k])
      begin
        if (hi[k] == 16'h0)
        begin
          gap[k] <= now - last_start;
          last_start <= now;
        end
        hi[k] <= hi[k] + 16'h1;
        lo[k] <= 16'h0;
      end
      else if (hi[k] != 16'h0)
      begin
        lo[k] <= lo[k] + 16'h1;
        if (lo[k] == QUIET[15:0])
        begin
          rep_valid <= 1'b1;
          rep_side <= k[0];
          rep_len <= hi[k];
          rep_gap <= gap[k];
          hi[k] <= 16'h0;
        end
      end
    end
  end
endmodule

// ### tb_top.sv
// self-checking bench for the fast-feed drive pulse generator
`timescale 1ns/1ps
`include "ffwave_defs.svh"
module tb_top;
  localparam int TK = 4;
  typedef struct {logic rd; logic [31:0] data; logic err;} xfer_type;
  typedef struct {logic [31:0] len; logic [31:0] gap;} step_type;
  logic        core_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        drive_out_a;
  logic        drive_out_b;
  logic        rep_valid;
  logic        rep_side;
  logic [15:0] rep_len;
  logic [15:0] rep_gap;
  logic        last_side;
  bit          armed;
  int          failures;
  int          comparisons;
  int          i;
  int          hi;
  logic [31:0] seed;
  logic [31:0] r;
  logic [31:0] nrm;
  logic [31:0] rev;
  xfer_type    xq[$];
  step_type    sq[$];
  xfer_type    xf;
  step_type    st;
  int          per [8] = '{`PER_16HZ, `PER_25HZ, `PER_32HZ, `PER_42HZ, `PER_51HZ, `PER_64HZ, `PER_85HZ, `PER_128HZ};

  fast_feed_pulse_waveform_gen #(.TICK_CYCLES(TK)) fast_feed_pulse_waveform_gen_i
  (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_out_a(drive_out_a), .drive_out_b(drive_out_b)
  );
  coil_model coil_model_i
  (
    .core_clk(core_clk), .rst(rst), .coil_a(drive_out_a), .coil_b(drive_out_b),
    .rep_valid(rep_valid), .rep_side(rep_side), .rep_len(rep_len), .rep_gap(rep_gap)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // d is write data, or the expected read data
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
    xq.push_back('{!wr, d, err});
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    while (pready !== 1'b1) @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // program, run n steps, stop and let the coils settle
  task automatic run(input string nm, input logic [31:0] ctl, nrm_v, rev_v, input int len, gap, n);
    int k;
    apb(1'b1, `OFS_NORMAL, nrm_v, 1'b0);
    apb(1'b1, `OFS_REVERSE, rev_v, 1'b0);
    armed = 1'b1;
    for (k = 0; k < n; k++) sq.push_back('{len, (k == 0) ? 0 : gap});
    apb(1'b1, `OFS_CTRL, ctl | 32'h1, 1'b0);
    for (k = 0; k < 8000 && sq.size() > 0; k++) @(posedge core_clk);
    check(sq.size(), 32'h0, "missing steps");
    sq.delete();
    armed = 1'b0;
    apb(1'b1, `OFS_CTRL, ctl, 1'b0);
    repeat (700) @(posedge core_clk);
    $display("test %s done", nm);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk)
  begin
    if (pready === 1'b1 && xq.size() > 0)
    begin
      xf = xq.pop_front();
      check({31'h0, pslverr}, {31'h0, xf.err}, "response");
      if (xf.rd)
        check(prdata, xf.data, "read data");
    end
    if (rep_valid === 1'b1)
    begin
      if (armed)
        check({31'h0, rep_side}, {31'h0, ~last_side}, "coil side");
      last_side = rep_side;
      if (armed && sq.size() > 0)
      begin
        st = sq.pop_front();
        check({16'h0, rep_len}, st.len, "high time");
        if (st.gap != 0)
          check({16'h0, rep_gap}, st.gap, "step spacing");
      end
    end
  end

  initial
  begin
    core_clk = 1'b0;
    forever #(`CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  end

  initial
  begin
    #(90000 * `CLK_PERIOD_NS);
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    last_side = 1'b1;
    seed = 32'h12;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    apb(1'b0, `OFS_CTRL, 32'h38, 1'b0);
    apb(1'b0, `OFS_NORMAL, 32'h0, 1'b0);
    apb(1'b0, `OFS_REVERSE, 32'h0, 1'b0);
    apb(1'b0, 12'h010, 32'h0, 1'b1);
    run("defaults", 32'h38, 32'h0, 32'h0, 24 * TK, `PER_128HZ * TK, 3);
    for (i = 0; i < 8; i++)
      run("clock code", {26'h0, i[2:0], 3'h0}, 32'h0, 32'h0, 24 * TK, per[i] * TK, 2);
    run("eight hz", 32'h3c, 32'h0, 32'h0, 24 * TK, `PER_8HZ * TK, 2);
    for (i = 0; i < 6; i++)
    begin
      r = rnd();
      nrm = {24'h0, r[7:0]} | ((i == 0) ? 32'h40 : 32'h0);
      hi = 12 + nrm[3:0] + (nrm[6] ? 0 : (4 + 2 * nrm[5:4]) * (nrm[7] ? 2 : 3));
      run("normal", 32'h10, nrm, 32'h0, hi * TK, `PER_32HZ * TK, 2);
      apb(1'b0, `OFS_NORMAL, nrm, 1'b0);
      rev = {23'h0, r[16:8]};
      hi = 3 + rev[2:0] + (rev[6] ? 28 : 20) + (rev[7] ? 8 : 4) * (rev[8] ? 2 : 3);
      run("reverse", 32'h12, 32'h0, rev, hi * TK, `PER_32HZ * TK, 2);
    end
    end_sim();
  end
endmodule
